// File: shared/tmc_defines.vh
// register map, field positions, reset values and mode codes of the timer block
`ifndef TMC_DEFINES_VH
`define TMC_DEFINES_VH
`define TMC_OFF_CTRL0 5'h00
`define TMC_OFF_CTRL1 5'h04
`define TMC_OFF_CNT_LO 5'h08
`define TMC_OFF_CNT_HI 5'h0C
`define TMC_OFF_CMPA_LO 5'h10
`define TMC_OFF_CMPA_HI 5'h14
`define TMC_OFF_CMPP_LO 5'h18
`define TMC_OFF_CMPP_HI 5'h1C
`define TMC_UNIT_NONE 2'h3
`define TMC_UNIT_COMPACT 2'h0
`define TMC_UNIT_WIDE_P 2'h2
`define TMC_CTRL0_MASK 8'hF8
`define TMC_CTRL_RESET 8'h00
`define TMC_C0_PAUSE 7
`define TMC_C0_CLK_HI 6
`define TMC_C0_CLK_LO 4
`define TMC_C0_ENABLE 3
`define TMC_C1_MODE_HI 7
`define TMC_C1_MODE_LO 6
`define TMC_C1_FN_HI 5
`define TMC_C1_FN_LO 4
`define TMC_C1_INIT 3
`define TMC_C1_POL 2
`define TMC_C1_DUTY_SEL 1
`define TMC_C1_CLR_SEL 0
`define TMC_MODE_CMP 2'h0
`define TMC_MODE_PULSE 2'h1
`define TMC_MODE_PWM 2'h2
`define TMC_MODE_TIMER 2'h3
`define TMC_FN_NONE 2'h0
`define TMC_FN_LOW 2'h1
`define TMC_FN_HIGH 2'h2
`define TMC_FN_TOGGLE 2'h3
`define TMC_CLK_SYS4 3'h0
`define TMC_CLK_SYS 3'h1
`define TMC_CLK_HI16 3'h2
`define TMC_CLK_HI64 3'h3
`define TMC_CLK_SUB0 3'h4
`define TMC_CLK_SUB1 3'h5
`define TMC_CLK_EXT_RISE 3'h6
`define TMC_CLK_EXT_FALL 3'h7
`define TMC_SYS4_LAST 2'h3
`define TMC_HI16_LAST 4'hF
`define TMC_HI64_LAST 6'h3F
`endif

// File: test/tmc_pin_drv.sv
// external clock pin driver standing in for the far side of the timer pins
`timescale 1ns/100ps
module tmc_pin_drv (
  // clock
  input wire pclk,
  // external clock pins, one per unit
  output reg [2:0] ext_clk
);
  initial ext_clk = 3'h0;
  // bursts of pulses, four cycles high and four low; level held low between bursts
  task pulses(input integer u, input integer k);
    integer i;
    begin
      for (i = 0; i < k; i = i + 1) begin
        @(posedge pclk);
        ext_clk[u] <= 1'b1;
        repeat (4) @(posedge pclk);
        ext_clk[u] <= 1'b0;
        repeat (3) @(posedge pclk);
      end
    end
  endtask
endmodule // tmc_pin_drv

// File: test/tmc_top_monitor.sv
// apb slave checks for the three-unit timer block
`timescale 1ns/100ps
module tmc_monitor #(
  parameter ADDR_W = 8
) (
  // apb clock and reset
  input wire pclk,
  input wire presetn,
  // apb signals
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr
);
  wire bad_w;
  wire rd_setup_w;
  // places outside the map and the read setup cycle
  assign bad_w = paddr[7] | (paddr[6:5] == 2'h3) | (paddr[1:0] != 2'h0);
  assign rd_setup_w = psel & ~penable & ~pwrite;
  default clocking mon_cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_err_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  chk_err_unmapped: assert property (psel && penable && bad_w |-> pslverr)
    else $error("unmapped access not refused");
  chk_err_mapped: assert property (psel && penable && !bad_w |-> !pslverr)
    else $error("mapped access refused");
  chk_rdata_upper: assert property (prdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  chk_rdata_zero: assert property (rd_setup_w && bad_w |=> prdata == 32'h00000000)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!rd_setup_w |=> $stable(prdata))
    else $error("read data moved without a read");
  chk_ctrl_low: assert property (rd_setup_w && !bad_w && paddr[4:0] == 5'h00
    |=> prdata[2:0] == 3'h0)
    else $error("control low bits not zero");
endmodule // tmc_monitor

// File: test/tmc_top_tb_top.sv
// self-checking bench for the three-unit timer block
`timescale 1ns/100ps
`define CHK(got, exp) begin comparisons = comparisons + 1; if ((got) !== (exp)) begin \
  miscompares = miscompares + 1; \
  $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end
module tmc_top_tb_top;
  localparam ADDR_W = 8;
  localparam MAX_CYC = 60000;
  reg pclk, presetn, psel, penable, pwrite, high_clock_tick, sub_clock_tick;
  reg [ADDR_W-1:0] paddr;
  reg [31:0] pwdata, rd;
  reg err;
  wire [31:0] prdata;
  wire pready, pslverr;
  wire [2:0] ext_w, pin_w;
  wire [5:0] irq_w;
  integer miscompares, comparisons, cycles, u, o, i, n, t, k, div, dummy;
  reg [15:0] cmpa_m [0:2];
  reg [7:0] buf_m [0:2];
  reg [7:0] bad_a [0:2];
  reg [7:0] lo, hi, lo2;
  reg [1:0] fn;
  reg [2:0] sel;
  tmc_top #(.ADDR_W(ADDR_W)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .high_clock_tick(high_clock_tick),
    .sub_clock_tick(sub_clock_tick), .compact_ext_clock_in(ext_w[0]),
    .standard_ext_clock_in(ext_w[1]), .periodic_ext_clock_in(ext_w[2]),
    .compact_out_pin(pin_w[0]), .standard_out_pin(pin_w[1]), .periodic_out_pin(pin_w[2]),
    .compact_irq_a(irq_w[0]), .compact_irq_p(irq_w[1]), .standard_irq_a(irq_w[2]),
    .standard_irq_p(irq_w[3]), .periodic_irq_a(irq_w[4]), .periodic_irq_p(irq_w[5]));
  tmc_pin_drv u_pins (.pclk(pclk), .ext_clk(ext_w));
  // clock and cycle ceiling
  initial pclk = 1'b0;
  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles = cycles + 1;
    if (cycles == MAX_CYC) begin
      miscompares = miscompares + 1;
      finish_test;
    end
  end
  // random internal clock ticks
  always @(posedge pclk) begin
    high_clock_tick <= (($urandom % 2) == 1);
    sub_clock_tick <= (($urandom % 2) == 1);
  end
  // one apb transfer; read data and error taken at the ready edge
  task apb(input reg w, input reg [7:0] a, input reg [7:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
        @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // wait for a request pulse, then count cycles to the next one
  task wait_irq(input integer q);
    begin
      n = 0;
      do begin
        @(posedge pclk);
        n = n + 1;
      end while (irq_w[q] !== 1'b1 && n < 3000);
      `CHK(irq_w[q], 1'b1)
    end
  endtask
  task meas(input integer q);
    begin
      wait_irq(q);
      t = 0;
      do begin
        @(posedge pclk);
        t = t + 1;
      end while (irq_w[q] !== 1'b1 && t < 3000);
    end
  endtask
  task finish_test;
    begin
      $display("miscompares %0d comparisons %0d", miscompares, comparisons);
      if (miscompares == 0 && comparisons > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask
  // main sequence
  initial begin
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    presetn = 1'b0;
    {miscompares, comparisons, cycles} = 0;
    bad_a[0] = 8'h60;
    bad_a[1] = 8'h82;
    bad_a[2] = 8'h05;
    dummy = $urandom(32'hd5aa687e);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    // every register of every unit reads zero after reset
    for (u = 0; u < 3; u = u + 1) begin
      for (o = 0; o < 8; o = o + 1) begin
        apb(1'b0, u * 32 + o * 4, 8'h00);
        `CHK({err, rd}, 33'h000000000)
      end
    end
    // unmapped places are refused
    for (i = 0; i < 3; i = i + 1) begin
      apb(1'b1, bad_a[i], 8'hFF);
      `CHK(err, 1'b1)
      apb(1'b0, bad_a[i], 8'h00);
      `CHK({err, rd}, 33'h100000000)
    end
    // low bytes through the shared buffer, low written first and high read first
    for (u = 0; u < 3; u = u + 1) begin
      {lo, hi, lo2} = $urandom;
      cmpa_m[u] = 16'h0000;
      buf_m[u] = lo;
      apb(1'b1, u * 32 + 8'h10, lo);
      apb(1'b0, u * 32 + 8'h10, 8'h00);
      `CHK(rd, {24'h000000, buf_m[u]})
      apb(1'b0, u * 32 + 8'h14, 8'h00);
      buf_m[u] = cmpa_m[u][7:0];
      `CHK(rd, {24'h000000, cmpa_m[u][15:8]})
      apb(1'b0, u * 32 + 8'h10, 8'h00);
      `CHK(rd, {24'h000000, buf_m[u]})
      apb(1'b1, u * 32 + 8'h10, lo);
      apb(1'b1, u * 32 + 8'h14, hi);
      cmpa_m[u] = {hi, lo};
      apb(1'b1, u * 32 + 8'h10, lo2);
      apb(1'b0, u * 32 + 8'h14, 8'h00);
      `CHK(rd, {24'h000000, cmpa_m[u][15:8]})
      apb(1'b0, u * 32 + 8'h10, 8'h00);
      `CHK(rd, {24'h000000, cmpa_m[u][7:0]})
    end
    // compare output on the standard unit: low, high, toggle on a match
    for (i = 1; i < 4; i = i + 1) begin
      fn = i;
      k = 3 + $urandom % 30;
      sel = (fn == 2'h3) ? 3'h0 : 3'h1;
      div = (fn == 2'h3) ? 4 : 1;
      apb(1'b1, 8'h20, 8'h00);
      apb(1'b1, 8'h30, k);
      apb(1'b1, 8'h34, 8'h00);
      apb(1'b1, 8'h24, {2'h0, fn, (fn == 2'h1), 3'h1});
      apb(1'b1, 8'h20, {1'b0, sel, 4'h8});
      repeat (2) @(posedge pclk);
      `CHK(pin_w[1], (fn == 2'h1))
      meas(2);
      `CHK(t, (k + 1) * div)
      repeat (2) @(posedge pclk);
      `CHK(pin_w[1], (fn == 2'h2))
      wait_irq(2);
      repeat (2) @(posedge pclk);
      `CHK(pin_w[1], (fn != 2'h1))
      `CHK(irq_w[3], 1'b0)
    end
    apb(1'b1, 8'h20, 8'h00);
    // comparator p of the compact unit on the top eight bits, clearing the counter
    apb(1'b1, 8'h10, 8'hFF);
    apb(1'b1, 8'h14, 8'hFF);
    apb(1'b1, 8'h1C, 8'h01);
    apb(1'b1, 8'h04, 8'h34);
    apb(1'b1, 8'h00, 8'h18);
    meas(1);
    `CHK(t, 257)
    `CHK(pin_w[0], 1'b1)
    `CHK(irq_w[0], 1'b0)
    apb(1'b1, 8'h00, 8'h00);
    // event counting on the periodic unit, rising then falling edge
    apb(1'b1, 8'h50, 8'hFF);
    apb(1'b1, 8'h54, 8'hFF);
    apb(1'b1, 8'h44, 8'hC1);
    for (i = 6; i < 8; i = i + 1) begin
      sel = i;
      k = 1 + $urandom % 20;
      apb(1'b1, 8'h40, 8'h00);
      apb(1'b1, 8'h40, {1'b0, sel, 4'h8});
      u_pins.pulses(2, k);
      repeat (6) @(posedge pclk);
      apb(1'b0, 8'h4C, 8'h00);
      `CHK(rd, 32'h00000000)
      apb(1'b0, 8'h48, 8'h00);
      `CHK(rd, k)
    end
    // pwm on the periodic unit: period from p, duty from a, active high
    k = 4 + $urandom % 40;
    div = 1 + $urandom % k;
    apb(1'b1, 8'h40, 8'h00);
    apb(1'b1, 8'h58, k);
    apb(1'b1, 8'h5C, 8'h00);
    apb(1'b1, 8'h50, div);
    apb(1'b1, 8'h54, 8'h00);
    apb(1'b1, 8'h44, 8'hA8);
    apb(1'b1, 8'h40, 8'h18);
    meas(5);
    `CHK(t, k + 1)
    o = 0;
    repeat (k + 1) begin
      @(posedge pclk);
      o = o + pin_w[2];
    end
    `CHK(o, div)
    meas(4);
    `CHK(t, k + 1)
    apb(1'b1, 8'h40, 8'h00);
    // single pulse on the standard unit, started by a rising edge on its pin
    k = 2 + $urandom % 30;
    apb(1'b1, 8'h30, k);
    apb(1'b1, 8'h34, 8'h00);
    apb(1'b1, 8'h24, 8'h48);
    apb(1'b1, 8'h20, 8'h18);
    repeat (2) @(posedge pclk);
    `CHK(pin_w[1], 1'b0)
    o = 0;
    fork
      u_pins.pulses(1, 1);
      repeat (k + 20) begin
        @(posedge pclk);
        o = o + pin_w[1];
      end
    join
    `CHK(o, k + 1)
    apb(1'b1, 8'h20, 8'h00);
    finish_test;
  end
endmodule // tmc_top_tb_top
bind tmc_top tmc_monitor #(.ADDR_W(ADDR_W)) u_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr));

// File: verilog/tmc_core.v
// counter, comparators, output pin and single pulse control of one timer unit
`timescale 1ns/100ps
`include "tmc_defines.vh"

module tmc_core #(
  parameter HAS_PULSE = 1'b1,
  parameter P_WIDE = 1'b0
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // configuration
  input wire enable,
  input wire pause,
  input wire [1:0] mode,
  input wire [1:0] out_fn,
  input wire init_lvl,
  input wire out_pol,
  input wire duty_sel,
  input wire clr_sel,
  input wire [15:0] cmp_a,
  input wire [15:0] cmp_p,
  // count tick and external trigger edge
  input wire count_tick,
  input wire ext_edge,
  // results
  output reg [15:0] count_q,
  output wire out_pin,
  output wire irq_a,
  output wire irq_p
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_PULSE = 2'b10;

  reg enable_q;
  reg lvl_q;
  reg lvl_d;
  reg out_q;
  reg irq_a_q;
  reg irq_p_q;
  reg [1:0] st_q;

  wire en_rise = enable & ~enable_q;
  wire pulse_mode = HAS_PULSE && (mode == `TMC_MODE_PULSE);
  wire pwm_mode = (mode == `TMC_MODE_PWM);
  wire trigger = enable & pulse_mode & (st_q == ST_IDLE) & ext_edge;
  // a narrow p holds only its high byte, matched against the top counter bits
  wire [15:0] p_full = P_WIDE ? cmp_p : {cmp_p[15:8], 8'h00};
  // equality of counter and comparator is a match, except that a narrow p of zero never matches
  wire hit_a = (count_q == cmp_a);
  wire hit_p = (count_q == p_full) && (P_WIDE || (cmp_p[15:8] != 8'h00));
  wire running = enable & ~pause & (~pulse_mode | (st_q == ST_PULSE));
  wire step = running & count_tick;
  // the period comparator clears the count; the other sets duty
  wire clr_hit = pwm_mode ? (duty_sel ? hit_a : hit_p) : (clr_sel ? hit_a : hit_p);
  wire [15:0] duty = duty_sel ? p_full : cmp_a;
  wire pwm_on = (count_q < duty);

  // next pin level before polarity; init_lvl is the active level in pwm and pulse
  always @* begin
    lvl_d = lvl_q;
    if (en_rise) begin
      lvl_d = (mode == `TMC_MODE_CMP) ? init_lvl : ~init_lvl;
    end else if (enable) begin
      case (mode)
        `TMC_MODE_CMP: begin
          if (step & hit_a) begin
            case (out_fn)
              `TMC_FN_LOW: lvl_d = 1'b0;
              `TMC_FN_HIGH: lvl_d = 1'b1;
              `TMC_FN_TOGGLE: lvl_d = ~lvl_q;
              default: lvl_d = lvl_q;
            endcase
          end
        end
        `TMC_MODE_PWM: begin
          case (out_fn)
            `TMC_FN_NONE: lvl_d = ~init_lvl;
            `TMC_FN_LOW: lvl_d = init_lvl;
            `TMC_FN_HIGH: lvl_d = pwm_on ? init_lvl : ~init_lvl;
            default: lvl_d = lvl_q;
          endcase
        end
        `TMC_MODE_PULSE: begin
          if (trigger) begin
            lvl_d = init_lvl;
          end else if (pulse_mode & step & hit_a) begin
            lvl_d = ~init_lvl;
          end
        end
        default: lvl_d = lvl_q;
      endcase
    end
  end

  // counter, pin and match pulses
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_q <= 1'b0;
      count_q <= 16'h0000;
      lvl_q <= 1'b0;
      out_q <= 1'b0;
      irq_a_q <= 1'b0;
      irq_p_q <= 1'b0;
    end else begin
      enable_q <= enable;
      lvl_q <= lvl_d;
      out_q <= lvl_d ^ out_pol;
      irq_a_q <= step & hit_a;
      irq_p_q <= step & hit_p;
      if (en_rise) begin
        count_q <= 16'h0000;
      end else if (step) begin
        // overflow wraps to zero by itself
        count_q <= (clr_hit | (pulse_mode & hit_a)) ? 16'h0000 : count_q + 16'h0001;
      end
    end
  end

  // single pulse sequencing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
    end else if (!enable || !pulse_mode) begin
      st_q <= ST_IDLE;
    end else begin
      case (st_q)
        ST_IDLE: if (trigger) st_q <= ST_PULSE;
        ST_PULSE: if (step & hit_a) st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  assign out_pin = out_q;
  assign irq_a = irq_a_q;
  assign irq_p = irq_p_q;

endmodule // tmc_core

// File: verilog/tmc_top.v
// three timer units with byte-buffered 16-bit registers behind an apb slave
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "tmc_defines.vh"

// Function
// - compact, standard and periodic units, shared core
// - pulse mode only on standard and periodic
// - edge-aligned pwm, duty or period adjustable
// - free-running up-counter, equality is a match, except a zero narrow p
// - match raises request, may clear counter
// - clock from system, high, sub or pin
// - external clock edge rising or falling
// - separate requests for comparators a and p
// - compare match drives pin high, low, toggle
// - pwm leaves on the compare output pin
// - clock pin triggers single pulse mode
// - high bytes direct, low bytes via buffer
// - low compare write only loads buffer
// - high compare write copies buffer low
// - high read captures low into buffer
// - low read returns the buffer
// - p 16-bit on periodic, else 8-bit on top bits; a 16-bit
// - counter cleared on enable, overflow, match
module tmc_top #(
  parameter ADDR_W = 8
) (
  // apb clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // internal clock ticks, one pclk cycle each
  input wire high_clock_tick,
  input wire sub_clock_tick,
  // external clock and trigger inputs
  input wire compact_ext_clock_in,
  input wire standard_ext_clock_in,
  input wire periodic_ext_clock_in,
  // timer output pins
  output wire compact_out_pin,
  output wire standard_out_pin,
  output wire periodic_out_pin,
  // compare match requests
  output wire compact_irq_a,
  output wire compact_irq_p,
  output wire standard_irq_a,
  output wire standard_irq_p,
  output wire periodic_irq_a,
  output wire periodic_irq_p
);

  // register state, one entry per unit; read data and tick divider counters shared
  reg [7:0] ctrl0_q [0:2];
  reg [7:0] ctrl1_q [0:2];
  reg [7:0] cmpa_lo_q [0:2];
  reg [7:0] cmpa_hi_q [0:2];
  reg [7:0] cmpp_lo_q [0:2];
  reg [7:0] cmpp_hi_q [0:2];
  reg [7:0] buf_q [0:2];
  reg [31:0] prdata_q;
  reg [7:0] rd_byte;
  reg [1:0] sys4_cnt_q;
  reg [5:0] hi_cnt_q;

  wire [2:0] ext_pin_w;
  wire [2:0] out_pin_w;
  wire [2:0] irq_a_w;
  wire [2:0] irq_p_w;
  wire [47:0] count_w;

  // selects a register of one unit
  function tmc_hit;
    input [ADDR_W-1:0] addr;
    input [1:0] unit;
    input [4:0] off;
    begin
      tmc_hit = (addr[6:5] == unit) && (addr[4:0] == off);
    end
  endfunction

  // address decode
  wire [1:0] unit_w = paddr[6:5];
  wire [4:0] off_w = paddr[4:0];
  wire [1:0] u_idx = (unit_w == `TMC_UNIT_NONE) ? `TMC_UNIT_COMPACT : unit_w;
  wire addr_ok = (paddr[ADDR_W-1:7] == 0) && (unit_w != `TMC_UNIT_NONE) &&
                 (off_w[1:0] == 2'h0);
  wire setup = psel & ~penable;
  wire wr_en = psel & penable & pwrite & addr_ok;
  // read data and buffer capture happen together in the setup cycle
  wire rd_en = setup & ~pwrite & addr_ok;
  wire wide_sel = (u_idx == `TMC_UNIT_WIDE_P);

  // apb answers in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata = prdata_q;

  // divided clock ticks shared by all units
  wire tick_sys4 = (sys4_cnt_q == `TMC_SYS4_LAST);
  wire tick_hi16 = high_clock_tick & (hi_cnt_q[3:0] == `TMC_HI16_LAST);
  wire tick_hi64 = high_clock_tick & (hi_cnt_q == `TMC_HI64_LAST);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys4_cnt_q <= 2'h0;
      hi_cnt_q <= 6'h00;
    end else begin
      sys4_cnt_q <= sys4_cnt_q + 2'h1;
      if (high_clock_tick) begin
        hi_cnt_q <= hi_cnt_q + 6'h01;
      end
    end
  end

  // register read mux
  always @* begin
    rd_byte = 8'h00;
    case (off_w)
      `TMC_OFF_CTRL0: rd_byte = ctrl0_q[u_idx];
      `TMC_OFF_CTRL1: rd_byte = ctrl1_q[u_idx];
      `TMC_OFF_CNT_LO: rd_byte = buf_q[u_idx];
      `TMC_OFF_CNT_HI: rd_byte = count_w[{u_idx, 4'h8} +: 8];
      `TMC_OFF_CMPA_LO: rd_byte = buf_q[u_idx];
      `TMC_OFF_CMPA_HI: rd_byte = cmpa_hi_q[u_idx];
      `TMC_OFF_CMPP_LO: rd_byte = wide_sel ? buf_q[u_idx] : 8'h00;
      `TMC_OFF_CMPP_HI: rd_byte = cmpp_hi_q[u_idx];
      default: rd_byte = 8'h00;
    endcase
  end

  // read data register, loaded in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (setup & ~pwrite) begin
      prdata_q <= addr_ok ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  assign ext_pin_w = {periodic_ext_clock_in, standard_ext_clock_in, compact_ext_clock_in};

  // one timer unit per index: 0 compact, 1 standard, 2 periodic
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_unit
      localparam [1:0] UNIT = (i == 0) ? 2'h0 : ((i == 1) ? 2'h1 : 2'h2);
      localparam WIDE = (i == 2);
      localparam PULSE = (i != 0);

      reg [1:0] ext_sync_q;
      reg ext_prev_q;
      reg tick;

      wire [2:0] clk_sel = ctrl0_q[i][`TMC_C0_CLK_HI:`TMC_C0_CLK_LO];
      wire ext_rise = ext_sync_q[1] & ~ext_prev_q;
      wire ext_fall = ~ext_sync_q[1] & ext_prev_q;
      wire ext_edge = (clk_sel == `TMC_CLK_EXT_FALL) ? ext_fall : ext_rise;

      // two-stage synchroniser then edge detect on the external pin
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ext_sync_q <= 2'b00;
          ext_prev_q <= 1'b0;
        end else begin
          ext_sync_q <= {ext_sync_q[0], ext_pin_w[i]};
          ext_prev_q <= ext_sync_q[1];
        end
      end

      // count tick source selection
      always @* begin
        case (clk_sel)
          `TMC_CLK_SYS4: tick = tick_sys4;
          `TMC_CLK_SYS: tick = 1'b1;
          `TMC_CLK_HI16: tick = tick_hi16;
          `TMC_CLK_HI64: tick = tick_hi64;
          `TMC_CLK_SUB0: tick = sub_clock_tick;
          `TMC_CLK_SUB1: tick = sub_clock_tick;
          `TMC_CLK_EXT_RISE: tick = ext_rise;
          `TMC_CLK_EXT_FALL: tick = ext_fall;
          default: tick = 1'b0;
        endcase
      end

      // control registers; the low bits of ctrl0 read as zero
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ctrl0_q[i] <= `TMC_CTRL_RESET;
          ctrl1_q[i] <= `TMC_CTRL_RESET;
        end else if (wr_en) begin
          if (tmc_hit(paddr, UNIT, `TMC_OFF_CTRL0)) begin
            ctrl0_q[i] <= pwdata[7:0] & `TMC_CTRL0_MASK;
          end
          if (tmc_hit(paddr, UNIT, `TMC_OFF_CTRL1)) begin
            ctrl1_q[i] <= pwdata[7:0];
          end
        end
      end

      // comparator a: high write also copies the buffer into the low byte
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cmpa_lo_q[i] <= 8'h00;
          cmpa_hi_q[i] <= 8'h00;
        end else if (wr_en && tmc_hit(paddr, UNIT, `TMC_OFF_CMPA_HI)) begin
          cmpa_hi_q[i] <= pwdata[7:0];
          cmpa_lo_q[i] <= buf_q[i];
        end
      end

      // comparator p: 16-bit through the buffer on the periodic unit only
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cmpp_lo_q[i] <= 8'h00;
          cmpp_hi_q[i] <= 8'h00;
        end else if (wr_en && tmc_hit(paddr, UNIT, `TMC_OFF_CMPP_HI)) begin
          cmpp_hi_q[i] <= pwdata[7:0];
          if (WIDE) begin
            cmpp_lo_q[i] <= buf_q[i];
          end
        end
      end

      // shared holding buffer for all low bytes of this unit
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          buf_q[i] <= 8'h00;
        end else if (wr_en && (tmc_hit(paddr, UNIT, `TMC_OFF_CMPA_LO) ||
                     (WIDE && tmc_hit(paddr, UNIT, `TMC_OFF_CMPP_LO)))) begin
          buf_q[i] <= pwdata[7:0];
        end else if (rd_en && tmc_hit(paddr, UNIT, `TMC_OFF_CNT_HI)) begin
          buf_q[i] <= count_w[16*i +: 8];
        end else if (rd_en && tmc_hit(paddr, UNIT, `TMC_OFF_CMPA_HI)) begin
          buf_q[i] <= cmpa_lo_q[i];
        end else if (WIDE && rd_en && tmc_hit(paddr, UNIT, `TMC_OFF_CMPP_HI)) begin
          buf_q[i] <= cmpp_lo_q[i];
        end
      end

      // the timer core of this unit
      tmc_core #(
        .HAS_PULSE(PULSE),
        .P_WIDE(WIDE)
      ) u_core (
        .pclk(pclk),
        .presetn(presetn),
        .enable(ctrl0_q[i][`TMC_C0_ENABLE]),
        .pause(ctrl0_q[i][`TMC_C0_PAUSE]),
        .mode(ctrl1_q[i][`TMC_C1_MODE_HI:`TMC_C1_MODE_LO]),
        .out_fn(ctrl1_q[i][`TMC_C1_FN_HI:`TMC_C1_FN_LO]),
        .init_lvl(ctrl1_q[i][`TMC_C1_INIT]),
        .out_pol(ctrl1_q[i][`TMC_C1_POL]),
        .duty_sel(ctrl1_q[i][`TMC_C1_DUTY_SEL]),
        .clr_sel(ctrl1_q[i][`TMC_C1_CLR_SEL]),
        .cmp_a({cmpa_hi_q[i], cmpa_lo_q[i]}),
        .cmp_p({cmpp_hi_q[i], cmpp_lo_q[i]}),
        .count_tick(tick),
        .ext_edge(ext_edge),
        .count_q(count_w[16*i +: 16]),
        .out_pin(out_pin_w[i]),
        .irq_a(irq_a_w[i]),
        .irq_p(irq_p_w[i])
      );
    end
  endgenerate

  // pins and requests of each unit
  assign compact_out_pin = out_pin_w[0];
  assign standard_out_pin = out_pin_w[1];
  assign periodic_out_pin = out_pin_w[2];
  assign compact_irq_a = irq_a_w[0];
  assign compact_irq_p = irq_p_w[0];
  assign standard_irq_a = irq_a_w[1];
  assign standard_irq_p = irq_p_w[1];
  assign periodic_irq_a = irq_a_w[2];
  assign periodic_irq_p = irq_p_w[2];

endmodule // tmc_top
